// file: hdl/flash_erase_regs.svh
// Register offsets, field positions, reset values and address map constants.
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

`define OFF_CLKDIV      8'h00
`define OFF_CONFIG      8'h04
`define OFF_STATUS      8'h08
`define OFF_CMDIDX      8'h0c
`define OFF_CMDWORD     8'h10
`define OFF_SECURITY    8'h14

`define DIV_LOADED_BIT  7
`define DIV_VALUE_W     7
`define DIV_RESET       7'h00
`define CFG_PENDING_BIT 0
`define ST_COMMAND_COMPLETE_FLAG_BIT     7
`define ST_ACCESS_ERROR_FLAG_BIT   5
`define ST_PROTECTION_VIOLATION_FLAG_BIT   4
`define ST_VERR_BIT     1
`define ST_VUNC_BIT     0

`define CMD_ERASE_BLOCK  8'h09
`define CMD_ERASE_SECTOR 8'h0a
`define CMDIDX_ERASE     3'h1

`define SEC_RESET        2'h3
`define SEC_UNSECURE     2'h2
`define SEC_BYTE_UNSEC   8'hfe
`define SEC_BYTE_ADDR    24'hff_ff0f

`define PF_BASE          24'hfc_0000
`define PF_TOP           24'hff_ffff
`define EE_BASE          24'h10_0000
`define EE_TOP           24'h10_07ff

`endif

// file: hdl/flash_erase_pkg.sv
// Types shared by the erase sequencer and its array operation engine.
`default_nettype none
package flash_erase_pkg;

	typedef enum logic [1:0] {SC_BLOCK, SC_SECTOR, SC_ALL} scope_e;
	typedef enum logic [1:0] {PH_ERASE, PH_VERIFY, PH_PROGRAM, PH_PVERIFY} phase_e;
	typedef enum logic [2:0] {E_IDLE, E_ERASE, E_VERIFY, E_PROG, E_PVERIFY,
		E_FINISH} eng_state_e;

	typedef struct packed {
		logic        strobe;
		phase_e      phase;
		scope_e      scope;
		logic [23:0] addr;
		logic [7:0]  data;
	} arr_req_s;

	typedef struct packed {
		logic done;
		logic err;
		logic uncorr;
	} arr_rsp_s;

	typedef struct packed {
		logic verr;
		logic vunc;
		logic vpass;
	} eng_result_s;

endpackage
`default_nettype wire

// file: hdl/flash_op_engine.sv
// Array operation engine: erase, verify and, for erase-all, security byte program.
`include "flash_erase_regs.svh"
`default_nettype none
module flash_op_engine
	import flash_erase_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        start,
	input  wire scope_e      kind,
	input  wire logic [23:0] addr,
	output logic             done,
	output eng_result_s      result,
	output arr_req_s         arr_req,
	input  wire arr_rsp_s    arr_rsp
);

	eng_state_e  state_q, state_d;
	scope_e      kind_q, kind_d;
	logic [23:0] addr_q, addr_d;
	logic        issued_q, issued_d;
	eng_result_s res_q, res_d;

	always_comb begin
		state_d  = state_q;
		kind_d   = kind_q;
		addr_d   = addr_q;
		issued_d = issued_q;
		res_d    = res_q;
		done     = 1'b0;
		arr_req  = '{strobe: 1'b0, phase: PH_ERASE, scope: kind_q,
			addr: addr_q, data: 8'h00};
		unique case (state_q)
			E_IDLE: begin
				if (start) begin
					kind_d   = kind;
					addr_d   = addr;
					issued_d = 1'b0;
					res_d    = '0;
					state_d  = E_ERASE;
				end
			end
			E_ERASE, E_VERIFY, E_PROG, E_PVERIFY: begin
				arr_req.strobe = ~issued_q;
				unique case (state_q)
					E_VERIFY: arr_req.phase = PH_VERIFY;
					E_PROG:   arr_req.phase = PH_PROGRAM;
					E_PVERIFY: arr_req.phase = PH_PVERIFY;
					default:  arr_req.phase = PH_ERASE;
				endcase
				if (state_q == E_PROG || state_q == E_PVERIFY) begin
					arr_req.addr = `SEC_BYTE_ADDR;
					arr_req.data = `SEC_BYTE_UNSEC;
				end
				if (~issued_q)
					issued_d = 1'b1;
				if (issued_q && arr_rsp.done) begin
					issued_d = 1'b0;
					unique case (state_q)
						E_ERASE: state_d = E_VERIFY;
						E_VERIFY: begin
							res_d.verr  = arr_rsp.err;
							res_d.vunc  = arr_rsp.uncorr;
							res_d.vpass = ~arr_rsp.err;
							// Security is only touched after a clean erase.
							if (kind_q == SC_ALL && ~arr_rsp.err)
								state_d = E_PROG;
							else
								state_d = E_FINISH;
						end
						E_PROG: state_d = E_PVERIFY;
						default: begin
							res_d.verr = res_q.verr | arr_rsp.err;
							res_d.vunc = res_q.vunc | arr_rsp.uncorr;
							state_d    = E_FINISH;
						end
					endcase
				end
			end
			E_FINISH: begin
				done    = 1'b1;
				state_d = E_IDLE;
			end
			default: state_d = E_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q  <= E_IDLE;
			kind_q   <= SC_BLOCK;
			addr_q   <= 24'h00_0000;
			issued_q <= 1'b0;
			res_q    <= '0;
		end else if (ce) begin
			state_q  <= state_d;
			kind_q   <= kind_d;
			addr_q   <= addr_d;
			issued_q <= issued_d;
			res_q    <= res_d;
		end
	end

	assign result = res_q;

endmodule
`default_nettype wire

// file: hdl/flash_erase_sequencer.sv
// Erase sequencer top: APB registers, command launch checks, erase-all request.
//
// Chosen here: register access over APB and the placing of the registers.
`include "flash_erase_regs.svh"
`default_nettype none
module flash_erase_sequencer
	import flash_erase_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        ERASE_ALL_REQ,
	input  wire logic        MODE_CMD_OK,
	input  wire logic        MODE_ERASE_ALL_OK,
	input  wire logic        PROT_PF_ANY,
	input  wire logic        PROT_EE_ANY,
	input  wire logic        PROT_SECTOR_HIT,
	output logic [23:0]      CMD_ADDR,
	output logic [1:0]       SECURITY_STATE,
	output logic             ERASE_ALL_PENDING,
	output arr_req_s         ARRAY_REQ,
	input  wire arr_rsp_s    ARRAY_RSP
);

	logic                    command_complete_flag_q, command_complete_flag_d;
	logic                    access_error_flag_q, access_error_flag_d;
	logic                    protection_violation_flag_q, protection_violation_flag_d;
	logic                    verr_q, verr_d;
	logic                    vunc_q, vunc_d;
	logic                    div_ld_q, div_ld_d;
	logic [`DIV_VALUE_W-1:0] div_q, div_d;
	logic                    pend_q, pend_d;
	logic                    armed_q, armed_d;
	logic [1:0]              sec_q, sec_d;
	logic [2:0]              idx_q, idx_d;
	logic [15:0]             word_q [2];
	logic [15:0]             word_d [2];
	logic [31:0]             rdata_q, rdata_d;

	logic        setup;
	logic        wr;
	logic        mapped;
	logic        busy;
	logic        launch;
	logic        launch_acc;
	logic        launch_prot;
	logic        all_start;
	logic        all_go;
	logic        cmd_go;
	logic        eng_start;
	logic        eng_done;
	scope_e      eng_kind;
	scope_e      run_kind;
	logic [7:0]  cmd_code;
	logic [23:0] cmd_addr;
	eng_result_s eng_res;

	function automatic logic in_pflash(input logic [23:0] a);
		return a >= `PF_BASE && a <= `PF_TOP;
	endfunction

	function automatic logic in_eeprom(input logic [23:0] a);
		return a >= `EE_BASE && a <= `EE_TOP;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return a == `OFF_CLKDIV || a == `OFF_CONFIG || a == `OFF_STATUS ||
			a == `OFF_CMDIDX || a == `OFF_CMDWORD || a == `OFF_SECURITY;
	endfunction

	assign cmd_code = word_q[0][15:8];
	assign cmd_addr = {word_q[0][7:0], word_q[1]};
	assign busy     = ~command_complete_flag_q;
	assign setup    = PSEL & ~PENABLE;
	assign mapped   = is_mapped(PADDR);
	// Writes while an operation runs are dropped so a stray access cannot
	// disturb the command words the engine is working from.
	assign wr       = PSEL & PENABLE & PWRITE & mapped & ~busy;

	// Launch checks for the two erase commands; anything else is refused.
	always_comb begin
		launch_acc  = 1'b0;
		launch_prot = 1'b0;
		eng_kind    = SC_BLOCK;
		if (!MODE_CMD_OK || !div_ld_q) begin
			launch_acc = 1'b1;
		end else if (cmd_code == `CMD_ERASE_BLOCK) begin
			eng_kind = SC_BLOCK;
			if (idx_q != `CMDIDX_ERASE)
				launch_acc = 1'b1;
			else if (in_pflash(cmd_addr))
				launch_acc = cmd_addr[2:0] != 3'h0;
			else if (in_eeprom(cmd_addr))
				launch_acc = cmd_addr[0];
			else
				launch_acc = 1'b1;
			// Protection is judged by the region the address falls in; a
			// bad address has already been refused above.
			if (in_pflash(cmd_addr))
				launch_prot = PROT_PF_ANY;
			else
				launch_prot = PROT_EE_ANY;
		end else if (cmd_code == `CMD_ERASE_SECTOR) begin
			eng_kind = SC_SECTOR;
			if (idx_q != `CMDIDX_ERASE || !in_pflash(cmd_addr) ||
				cmd_addr[2:0] != 3'h0)
				launch_acc = 1'b1;
			launch_prot = PROT_SECTOR_HIT;
		end else begin
			launch_acc = 1'b1;
		end
		if (launch_acc)
			launch_prot = 1'b0;
	end

	// A launch is a one written to the complete flag while it is set and
	// no earlier error is still pending.
	assign launch = wr && PADDR == `OFF_STATUS && PWDATA[`ST_COMMAND_COMPLETE_FLAG_BIT] &&
		command_complete_flag_q && !access_error_flag_q && !protection_violation_flag_q;
	// One run per assertion of the level request, never while busy. A
	// command launched in the same cycle goes first; the held request
	// then starts its run once that command has finished.
	assign all_start = ERASE_ALL_REQ & armed_q & ~busy & ~pend_q &
		~launch;
	// A request that fails the mode or divider check only flags an error.
	assign all_go    = all_start & MODE_ERASE_ALL_OK & div_ld_q;
	assign cmd_go    = launch & ~launch_acc & ~launch_prot;
	// Protection inputs are deliberately not consulted for erase-all.
	assign eng_start = cmd_go | all_go;
	assign run_kind  = all_go ? SC_ALL : eng_kind;

	always_comb begin
		command_complete_flag_d   = command_complete_flag_q;
		access_error_flag_d = access_error_flag_q;
		protection_violation_flag_d = protection_violation_flag_q;
		verr_d   = verr_q;
		vunc_d   = vunc_q;
		div_ld_d = div_ld_q;
		div_d    = div_q;
		pend_d   = pend_q;
		armed_d  = armed_q;
		sec_d    = sec_q;
		idx_d    = idx_q;
		word_d   = word_q;
		rdata_d  = rdata_q;

		// Read data is taken in the setup cycle, so the access edge that
		// follows can always complete with no wait state.
		if (setup) begin
			rdata_d = 32'h0000_0000;
			unique case (PADDR)
				`OFF_CLKDIV: begin
					rdata_d[`DIV_LOADED_BIT] = div_ld_q;
					rdata_d[`DIV_VALUE_W-1:0] = div_q;
				end
				`OFF_CONFIG:  rdata_d[`CFG_PENDING_BIT] = pend_q;
				`OFF_STATUS: begin
					rdata_d[`ST_COMMAND_COMPLETE_FLAG_BIT]   = command_complete_flag_q;
					rdata_d[`ST_ACCESS_ERROR_FLAG_BIT] = access_error_flag_q;
					rdata_d[`ST_PROTECTION_VIOLATION_FLAG_BIT] = protection_violation_flag_q;
					rdata_d[`ST_VERR_BIT]   = verr_q;
					rdata_d[`ST_VUNC_BIT]   = vunc_q;
				end
				`OFF_CMDIDX:  rdata_d[2:0] = idx_q;
				`OFF_CMDWORD: begin
					// Indices beyond the two command words read as zero.
					if (idx_q < 3'h2)
						rdata_d[15:0] = word_q[idx_q[0]];
				end
				`OFF_SECURITY: rdata_d[1:0] = sec_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end

		// The access and protection error flags are write-one-to-clear; later hardware sets override.
		if (wr) begin
			unique case (PADDR)
				`OFF_CLKDIV: begin
					div_d    = PWDATA[`DIV_VALUE_W-1:0];
					div_ld_d = 1'b1;
				end
				`OFF_STATUS: begin
					if (PWDATA[`ST_ACCESS_ERROR_FLAG_BIT])
						access_error_flag_d = 1'b0;
					if (PWDATA[`ST_PROTECTION_VIOLATION_FLAG_BIT])
						protection_violation_flag_d = 1'b0;
				end
				`OFF_CMDIDX: idx_d = PWDATA[2:0];
				`OFF_CMDWORD: begin
					if (idx_q < 3'h2)
						word_d[idx_q[0]] = PWDATA[15:0];
				end
				default: ;
			endcase
		end

		if (launch) begin
			verr_d = 1'b0;
			vunc_d = 1'b0;
			if (launch_acc)
				access_error_flag_d = 1'b1;
			if (launch_prot)
				protection_violation_flag_d = 1'b1;
			if (cmd_go)
				command_complete_flag_d = 1'b0;
		end

		// The request must be seen low once before another run is accepted.
		if (!ERASE_ALL_REQ)
			armed_d = 1'b1;
		if (all_start) begin
			armed_d = 1'b0;
			if (!all_go) begin
				access_error_flag_d = 1'b1;
			end else begin
				pend_d = 1'b1;
				command_complete_flag_d = 1'b0;
				verr_d = 1'b0;
				vunc_d = 1'b0;
			end
		end

		// Completion is applied last so hardware sets beat software clears.
		if (eng_done) begin
			command_complete_flag_d = 1'b1;
			if (eng_res.verr)
				verr_d = 1'b1;
			if (eng_res.vunc)
				vunc_d = 1'b1;
			if (pend_q) begin
				pend_d   = 1'b0;
				div_ld_d = 1'b0;
				div_d    = `DIV_RESET;
				if (eng_res.vpass)
					sec_d = `SEC_UNSECURE;
			end
		end
	end

	// Every register holds its value while the clock enable is low.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			command_complete_flag_q    <= 1'b1;
			access_error_flag_q  <= 1'b0;
			protection_violation_flag_q  <= 1'b0;
			verr_q    <= 1'b0;
			vunc_q    <= 1'b0;
			div_ld_q  <= 1'b0;
			div_q     <= `DIV_RESET;
			pend_q    <= 1'b0;
			armed_q   <= 1'b0;
			sec_q     <= `SEC_RESET;
			idx_q     <= 3'h0;
			word_q[0] <= 16'h0000;
			word_q[1] <= 16'h0000;
			rdata_q   <= 32'h0000_0000;
		end else if (CE) begin
			command_complete_flag_q   <= command_complete_flag_d;
			access_error_flag_q <= access_error_flag_d;
			protection_violation_flag_q <= protection_violation_flag_d;
			verr_q   <= verr_d;
			vunc_q   <= vunc_d;
			div_ld_q <= div_ld_d;
			div_q    <= div_d;
			pend_q   <= pend_d;
			armed_q  <= armed_d;
			sec_q    <= sec_d;
			idx_q    <= idx_d;
			word_q   <= word_d;
			rdata_q  <= rdata_d;
		end
	end

	// The engine owns the array handshake; this block only starts it and
	// folds its verify results into the status flags and the security state.
	flash_op_engine u_engine (
		.clk     (MCLK),
		.rst_n   (RST_N),
		.ce      (CE),
		.start   (eng_start),
		.kind    (run_kind),
		.addr    (cmd_addr),
		.done    (eng_done),
		.result  (eng_res),
		.arr_req (ARRAY_REQ),
		.arr_rsp (ARRAY_RSP)
	);

	// Zero wait states: read data is captured in the setup cycle.
	assign PREADY            = 1'b1;
	assign PSLVERR           = PSEL & PENABLE & ~mapped;
	assign PRDATA            = rdata_q;
	assign CMD_ADDR          = cmd_addr;
	assign SECURITY_STATE    = sec_q;
	assign ERASE_ALL_PENDING = pend_q;

endmodule
`default_nettype wire

// file: tb/flash_erase_sequencer_asserts.sv
// Port-level checker for the erase sequencer.
`include "flash_erase_regs.svh"
`default_nettype none
module flash_erase_sequencer_asserts
	import flash_erase_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR,
	input  wire logic        ERASE_ALL_REQ,
	input  wire logic        MODE_ERASE_ALL_OK,
	input  wire logic [23:0] CMD_ADDR,
	input  wire logic [1:0]  SECURITY_STATE,
	input  wire logic        ERASE_ALL_PENDING,
	input  wire arr_req_s    ARRAY_REQ,
	input  wire arr_rsp_s    ARRAY_RSP
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	sequence all_erase_s;
		ARRAY_REQ.strobe && ARRAY_REQ.scope == SC_ALL &&
			ARRAY_REQ.phase == PH_ERASE;
	endsequence
	sequence req_seen_s;
		$past(ERASE_ALL_REQ) && $past(MODE_ERASE_ALL_OK);
	endsequence
	ready_const_a: assert property (PREADY)
		else $error("pready low");
	slverr_access_a: assert property (PSLVERR |-> PSEL && PENABLE)
		else $error("slave error outside access");
	strobe_pulse_a: assert property (ARRAY_REQ.strobe |=> !ARRAY_REQ.strobe)
		else $error("strobe longer than one cycle");
	run_start_a: assert property ($rose(ERASE_ALL_PENDING) |-> all_erase_s)
		else $error("erase-all did not start");
	run_cause_a: assert property ($rose(ERASE_ALL_PENDING) |-> req_seen_s)
		else $error("erase-all without request");
	all_scope_a: assert property (ARRAY_REQ.strobe &&
		ARRAY_REQ.scope == SC_ALL |-> ERASE_ALL_PENDING)
		else $error("full erase while not pending");
	cmd_addr_a: assert property (ARRAY_REQ.strobe && ARRAY_REQ.scope != SC_ALL
		|-> ARRAY_REQ.addr == CMD_ADDR && !ERASE_ALL_PENDING)
		else $error("command address mismatch");
	sec_prog_a: assert property (ARRAY_REQ.strobe &&
		ARRAY_REQ.phase inside {PH_PROGRAM, PH_PVERIFY} |->
		ARRAY_REQ.addr == `SEC_BYTE_ADDR && ARRAY_REQ.scope == SC_ALL &&
		(ARRAY_REQ.phase != PH_PROGRAM ||
		ARRAY_REQ.data == `SEC_BYTE_UNSEC))
		else $error("security byte program wrong");
	sec_release_a: assert property ($changed(SECURITY_STATE) |->
		SECURITY_STATE == `SEC_UNSECURE && $past(ERASE_ALL_PENDING))
		else $error("security changed outside erase-all");
	run_end_a: assert property ($fell(ERASE_ALL_PENDING) |->
		$past(ARRAY_RSP.done, 2))
		else $error("pending cleared early");
endmodule
`default_nettype wire

// file: tb/flash_array_model.sv
// Behavioural flash array answering erase, verify and program requests.
`default_nettype none
module flash_array_model
	import flash_erase_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire arr_req_s   req,
	input  wire logic [3:0] lat,
	input  wire logic       bad,
	input  wire logic       unc,
	output arr_rsp_s        rsp,
	output logic [7:0]      n_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       busy_q;
	logic       tog_q;
	logic [3:0] cnt_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_q <= 1'h0;
			cnt_q <= 4'h0;
			n_req <= 8'h0;
		end else if (req.strobe) begin
			busy_q <= 1'h1;
			cnt_q <= lat;
			n_req <= n_req + 8'h1;
		end else if (busy_q && cnt_q == 4'h0) begin
			busy_q <= 1'h0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 4'h1;
		end
		tog_q <= rst_n ? !tog_q : 1'h0;
	end
	// Error lines toggle outside done so that stale values are never trusted.
	always_comb begin
		rsp.done = busy_q && cnt_q == 4'h0;
		rsp.err = rsp.done ? bad : tog_q;
		rsp.uncorr = rsp.done ? unc : !tog_q;
	end
endmodule
`default_nettype wire

// file: tb/tb_flash_erase_sequencer.sv
// Self-checking bench for the erase sequencer over APB.
`include "flash_erase_regs.svh"
`default_nettype none
module tb_flash_erase_sequencer
	import flash_erase_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slv;
	logic ERASE_ALL_REQ, MODE_CMD_OK, MODE_ERASE_ALL_OK, bad, unc;
	logic PROT_PF_ANY, PROT_EE_ANY, PROT_SECTOR_HIT, ERASE_ALL_PENDING;
	logic [7:0]  PADDR;
	logic [7:0]  n_req;
	logic [3:0]  lat;
	logic [31:0] PWDATA, PRDATA;
	logic [23:0] CMD_ADDR;
	logic [1:0]  SECURITY_STATE;
	arr_req_s    ARRAY_REQ;
	arr_rsp_s    ARRAY_RSP;
	int          fail_count, comparisons, cycles, tn;
	flash_erase_sequencer dut_u (.MCLK, .RST_N, .CE, .PSEL, .PENABLE,
		.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.ERASE_ALL_REQ, .MODE_CMD_OK, .MODE_ERASE_ALL_OK, .PROT_PF_ANY,
		.PROT_EE_ANY, .PROT_SECTOR_HIT, .CMD_ADDR, .SECURITY_STATE,
		.ERASE_ALL_PENDING, .ARRAY_REQ, .ARRAY_RSP);
	flash_array_model arr_u (.clk(MCLK), .rst_n(RST_N), .req(ARRAY_REQ),
		.lat, .bad, .unc, .rsp(ARRAY_RSP), .n_req);
	initial begin
		MCLK = 1'h0;
		forever #4 MCLK = ~MCLK;
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge MCLK);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, a, d};
		@(posedge MCLK);
		PENABLE <= 1'h1;
		do @(posedge MCLK); while (PREADY !== 1'h1);
		r = PRDATA;
		slv = PSLVERR;
		{PSEL, PENABLE} <= 2'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'h1, a, d, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'h0, a, 32'h0, r);
		chk($sformatf("reg %h", a), r, e);
	endtask
	// Polling is bounded so a stuck busy flag cannot hang the run.
	task automatic wait_done(output logic [31:0] r);
		int i;
		i = 0;
		do begin
			apb(1'h0, `OFF_STATUS, 32'h0, r);
			i++;
		end while (r[7] !== 1'h1 && i < 60);
	endtask
	task automatic fin();
		wr(`OFF_STATUS, 32'h30);
		tn++;
		$display("test %0d done", tn);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [23:0] ad,
		input logic [2:0] ix, input logic [5:0] cf, input logic [7:0] ex, nr);
		logic [31:0] r;
		logic [7:0]  n0;
		n0 = n_req;
		{MODE_CMD_OK, PROT_PF_ANY, PROT_EE_ANY, PROT_SECTOR_HIT, bad, unc} <= cf;
		wr(`OFF_CMDIDX, 32'h0);
		wr(`OFF_CMDWORD, {16'h0, c, ad[23:16]});
		wr(`OFF_CMDIDX, 32'h1);
		wr(`OFF_CMDWORD, {16'h0, ad[15:0]});
		wr(`OFF_CMDIDX, {29'h0, ix});
		chk("cmd addr", {8'h0, CMD_ADDR}, {8'h0, ad});
		wr(`OFF_STATUS, 32'h80);
		apb(1'h0, `OFF_STATUS, 32'h0, r);
		chk("busy", {31'h0, r[7]}, {31'h0, nr == 8'h0});
		wait_done(r);
		chk("status", r, {24'h0, ex});
		chk("requests", {24'h0, n_req - n0}, {24'h0, nr});
		fin();
	endtask
	task automatic ea(input logic [2:0] cf, input logic [7:0] ex, nr,
		input logic [1:0] sec);
		logic [31:0] r;
		logic [7:0]  n0;
		n0 = n_req;
		{MODE_ERASE_ALL_OK, bad, unc} <= cf;
		{PROT_PF_ANY, PROT_EE_ANY} <= 2'h3;
		@(posedge MCLK);
		ERASE_ALL_REQ <= 1'h1;
		rdc(`OFF_CONFIG, {31'h0, nr != 8'h0});
		wait_done(r);
		chk("status", r, {24'h0, ex});
		chk("requests", {24'h0, n_req - n0}, {24'h0, nr});
		chk("security", {30'h0, SECURITY_STATE}, {30'h0, sec});
		rdc(`OFF_SECURITY, {30'h0, sec});
		rdc(`OFF_CONFIG, 32'h0);
		repeat (20) @(posedge MCLK);
		chk("rerun", {24'h0, n_req - n0}, {24'h0, nr});
		ERASE_ALL_REQ <= 1'h0;
		fin();
	endtask
	initial begin
		{CE, PSEL, PENABLE, PWRITE, PADDR, PWDATA, RST_N} = {1'h1, 44'h0};
		{ERASE_ALL_REQ, MODE_CMD_OK, MODE_ERASE_ALL_OK, bad, unc} = 5'h0;
		{PROT_PF_ANY, PROT_EE_ANY, PROT_SECTOR_HIT} = 3'h0;
		lat = 4'h2;
		repeat (12) @(posedge MCLK);
		RST_N <= 1'h1;
		rdc(`OFF_STATUS, 32'h80);
		rdc(`OFF_SECURITY, {30'h0, `SEC_RESET});
		rdc(8'h18, 32'h0);
		chk("slave error", {31'h0, slv}, 32'h1);
		ea(3'h4, 8'ha0, 8'h0, `SEC_RESET);
		wr(`OFF_CLKDIV, 32'h5);
		rdc(`OFF_CLKDIV, 32'h85);
		ea(3'h0, 8'ha0, 8'h0, `SEC_RESET);
		lat = 4'h6;
		ea(3'h6, 8'h82, 8'h2, `SEC_RESET);
		rdc(`OFF_CLKDIV, 32'h0);
		wr(`OFF_CLKDIV, 32'h5);
		ea(3'h7, 8'h83, 8'h2, `SEC_RESET);
		wr(`OFF_CLKDIV, 32'h5);
		ea(3'h4, 8'h80, 8'h4, `SEC_UNSECURE);
		rdc(`OFF_CLKDIV, 32'h0);
		lat = 4'h1;
		cmd(`CMD_ERASE_BLOCK, 24'hfc_0000, 3'h1, 6'h20, 8'ha0, 8'h0);
		wr(`OFF_CLKDIV, 32'h5);
		cmd(`CMD_ERASE_BLOCK, 24'hfc_0000, 3'h1, 6'h20, 8'h80, 8'h2);
		cmd(`CMD_ERASE_BLOCK, 24'hfc_0000, 3'h0, 6'h20, 8'ha0, 8'h0);
		cmd(`CMD_ERASE_BLOCK, 24'hfc_0004, 3'h1, 6'h20, 8'ha0, 8'h0);
		cmd(`CMD_ERASE_BLOCK, 24'h10_0001, 3'h1, 6'h20, 8'ha0, 8'h0);
		cmd(`CMD_ERASE_BLOCK, 24'h10_0002, 3'h1, 6'h20, 8'h80, 8'h2);
		cmd(`CMD_ERASE_BLOCK, 24'h20_0000, 3'h1, 6'h20, 8'ha0, 8'h0);
		cmd(`CMD_ERASE_BLOCK, 24'hfc_0000, 3'h1, 6'h30, 8'h90, 8'h0);
		cmd(`CMD_ERASE_BLOCK, 24'h10_0000, 3'h1, 6'h28, 8'h90, 8'h0);
		cmd(`CMD_ERASE_BLOCK, 24'h10_0000, 3'h1, 6'h30, 8'h80, 8'h2);
		cmd(`CMD_ERASE_BLOCK, 24'hfc_0000, 3'h1, 6'h22, 8'h82, 8'h2);
		cmd(`CMD_ERASE_SECTOR, 24'hfc_0000, 3'h1, 6'h20, 8'h80, 8'h2);
		cmd(`CMD_ERASE_SECTOR, 24'hfc_0001, 3'h1, 6'h20, 8'ha0, 8'h0);
		cmd(`CMD_ERASE_SECTOR, 24'h10_0000, 3'h1, 6'h20, 8'ha0, 8'h0);
		cmd(`CMD_ERASE_SECTOR, 24'hfc_0000, 3'h1, 6'h24, 8'h90, 8'h0);
		cmd(`CMD_ERASE_SECTOR, 24'hfc_0000, 3'h1, 6'h23, 8'h83, 8'h2);
		cmd(`CMD_ERASE_BLOCK, 24'hfc_0000, 3'h1, 6'h00, 8'ha0, 8'h0);
		cmd(8'h0b, 24'hfc_0000, 3'h1, 6'h20, 8'ha0, 8'h0);
		// A write made while the clock enable is low must not land.
		CE <= 1'h0;
		wr(`OFF_CLKDIV, 32'h7);
		CE <= 1'h1;
		rdc(`OFF_CLKDIV, 32'h85);
		stop_test();
	end
endmodule
bind flash_erase_sequencer flash_erase_sequencer_asserts chk_u (.MCLK,
	.RST_N, .PSEL, .PENABLE, .PREADY, .PSLVERR, .ERASE_ALL_REQ,
	.MODE_ERASE_ALL_OK, .CMD_ADDR, .SECURITY_STATE, .ERASE_ALL_PENDING,
	.ARRAY_REQ, .ARRAY_RSP);
`default_nettype wire
